// *** rtl/cofd_operand_decoder.sv ***
`timescale 1ns/1ps
// How it works
// [RULE1] Add opcode 04: source byte, then destination
// [RULE2] Escaped field Ex selects working register x
// [RULE3] Plain register field addresses 0 through 255
// [RULE4] Bit select is three bits, 0-7
// [RULE5] Relative offset signed, added to next PC
// [RULE6] Register pair address even, 00H-FEH
// [RULE7] Working pair index even, 0-14
// [RULE8] Wide register operand is twelve bits
// [RULE9] Direct address is sixteen bits
// [RULE10] Index displacement signed, added to base
// [RULE11] Immediate byte taken straight from stream
// [RULE12] Vector operand is a full byte
// [RULE13] Polarity is a single bit
// [RULE14] Working index n maps to bank base plus n
module cofd_operand_decoder
  import cofd_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // Instruction bytes from fetch, with next PC, index base and working bank base
  input  wire logic        byte_valid_in,
  input  wire logic [7:0]  byte_in,
  input  wire logic        opc_start_in,
  input  wire logic [3:0]  kind_in,
  input  wire logic [15:0] next_pc_in,
  input  wire logic [15:0] index_base_in,
  input  wire logic [7:0]  working_bank_base_in,
  // Decoded operands
  output logic             add_done_out,
  output logic [7:0]       src_loc_out,
  output logic [7:0]       dst_loc_out,
  output logic             op_valid_out,
  output logic [7:0]       reg_loc_out,
  output logic [7:0]       pair_loc_out,
  output logic [11:0]      wide_file_operand_out,
  output logic [15:0]      full_16bit_location_out,
  output logic [7:0]       literal_byte_operand_out,
  output logic [7:0]       vector_out,
  output logic [2:0]       bit_sel_out,
  output logic             polarity_out,
  output logic [15:0]      branch_target_out,
  output logic [15:0]      indexed_loc_out
);

  typedef enum logic [2:0] {
    COFD_IDLE = 3'b001,
    COFD_SRC  = 3'b010,
    COFD_DST  = 3'b100
  } cofd_state_e;

  typedef struct packed {
    cofd_state_e st;
    logic        add_done;
    logic [7:0]  src_loc;
    logic [7:0]  dst_loc;
    logic        op_valid;
    logic [7:0]  reg_loc;
    logic [7:0]  pair_loc;
    logic [3:0]  wide_hi;
    logic [11:0] wide;
    logic [7:0]  da_hi;
    logic [15:0] da;
    logic [7:0]  imm;
    logic [7:0]  vec;
    logic [2:0]  bit_sel;
    logic        pol;
    logic [15:0] target;
    logic [15:0] indexed;
  } cofd_state_s;

  // Reset image of the whole state, built from the package reset values
  localparam cofd_state_s COFD_RST_STATE = '{
    st:       COFD_IDLE,
    add_done: 1'h0,
    src_loc:  COFD_RST_BYTE,
    dst_loc:  COFD_RST_BYTE,
    op_valid: 1'h0,
    reg_loc:  COFD_RST_BYTE,
    pair_loc: COFD_RST_BYTE,
    wide_hi:  COFD_RST_ADDR12[11:8],
    wide:     COFD_RST_ADDR12,
    da_hi:    COFD_RST_ADDR16[15:8],
    da:       COFD_RST_ADDR16,
    imm:      COFD_RST_BYTE,
    vec:      COFD_RST_BYTE,
    bit_sel:  3'h0,
    pol:      1'h0,
    target:   COFD_RST_ADDR16,
    indexed:  COFD_RST_ADDR16
  };

  cofd_state_s s_q;
  cofd_state_s s_d;
  logic [7:0]  mapped_loc;
  logic        mapped_esc;

  // Sign extension shared by relative and indexed displacements
  function automatic logic [15:0] cofd_sext(input logic [7:0] b);
    cofd_sext = {{8{b[7]}}, b};
  endfunction : cofd_sext

  // Escape test shared by the register map checks
  function automatic logic cofd_is_esc(input logic [7:0] f);
    cofd_is_esc = (f[7:4] == COFD_ESC_NIBBLE);
  endfunction : cofd_is_esc

  ////////////////////////////////////////////////////////////////////////////
  cofd_reg_map u_map (
    .field_in             (byte_in),
    .working_bank_base_in (working_bank_base_in),
    .loc_out              (mapped_loc),
    .escaped_out          (mapped_esc)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d          = s_q;
    s_d.add_done = 1'b0;
    s_d.op_valid = 1'b0;
    // Add sequence: opcode, then source, then destination
    case (s_q.st)
      COFD_IDLE:
      begin
        if (byte_valid_in && opc_start_in && byte_in == COFD_OPC_ADD_RR) // RULE1
        begin
          s_d.st = COFD_SRC;
        end
      end
      COFD_SRC:
      begin
        if (byte_valid_in)
        begin
          s_d.src_loc = mapped_loc; // RULE1
          s_d.st      = COFD_DST;
        end
      end
      COFD_DST:
      begin
        if (byte_valid_in)
        begin
          s_d.dst_loc  = mapped_loc; // RULE1
          s_d.add_done = 1'b1;
          s_d.st       = COFD_IDLE;
        end
      end
      default:
      begin
        s_d.st = COFD_IDLE;
      end
    endcase
    // Standalone operand bytes, tagged by the fetch side
    if (byte_valid_in && !opc_start_in && s_q.st == COFD_IDLE)
    begin
      s_d.op_valid = 1'b1;
      case (kind_in)
        COFD_K_REG:     s_d.reg_loc = mapped_loc; // RULE3
        // Low bit forced clear: an odd pair address would straddle two pairs
        COFD_K_PAIR:    s_d.pair_loc = {byte_in[7:1], 1'b0}; // RULE6
        COFD_K_WPAIR:   s_d.pair_loc = working_bank_base_in + {4'h0, byte_in[3:1], 1'b0}; // RULE7
        COFD_K_WIDE_HI:
        begin
          s_d.wide_hi  = byte_in[3:0];
          s_d.op_valid = 1'b0;
        end
        COFD_K_WIDE_LO: s_d.wide = {s_q.wide_hi, byte_in}; // RULE8
        COFD_K_DA_HI:
        begin
          s_d.da_hi    = byte_in;
          s_d.op_valid = 1'b0;
        end
        COFD_K_DA_LO:   s_d.da = {s_q.da_hi, byte_in}; // RULE9
        COFD_K_IMM:     s_d.imm = byte_in; // RULE11
        COFD_K_VEC:     s_d.vec = byte_in; // RULE12
        COFD_K_BITP:
        begin
          s_d.bit_sel = byte_in[COFD_BIT_LSB +: 3]; // RULE4
          s_d.pol     = byte_in[COFD_POL_POS]; // RULE13
        end
        COFD_K_REL:     s_d.target = next_pc_in + cofd_sext(byte_in); // RULE5
        COFD_K_IDX:     s_d.indexed = index_base_in + cofd_sext(byte_in); // RULE10
        default:        s_d.op_valid = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_q <= COFD_RST_STATE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign add_done_out             = s_q.add_done;
  assign src_loc_out              = s_q.src_loc;
  assign dst_loc_out              = s_q.dst_loc;
  assign op_valid_out             = s_q.op_valid;
  assign reg_loc_out              = s_q.reg_loc;
  assign pair_loc_out             = s_q.pair_loc;
  assign wide_file_operand_out    = s_q.wide;
  assign full_16bit_location_out  = s_q.da;
  assign literal_byte_operand_out = s_q.imm;
  assign vector_out               = s_q.vec;
  assign bit_sel_out              = s_q.bit_sel;
  assign polarity_out             = s_q.pol;
  assign branch_target_out        = s_q.target;
  assign indexed_loc_out          = s_q.indexed;

  ////////////////////////////////////////////////////////////////////////////
  a_add_order: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE1
    add_done_out |-> $past(s_q.st) == COFD_DST)
    else $error("add done without destination phase");

  a_src_capture: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE1
    s_q.st == COFD_SRC && byte_valid_in
    |=> src_loc_out == $past(mapped_loc) && s_q.st == COFD_DST)
    else $error("source byte not captured");

  a_dst_capture: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE1
    add_done_out |-> dst_loc_out == $past(mapped_loc) && s_q.st == COFD_IDLE)
    else $error("destination byte not captured");

  // Bytes inside an add belong to it, so no standalone kind may report them
  a_add_refuse: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE1
    s_q.st != COFD_IDLE |=> !op_valid_out)
    else $error("standalone operand during add");

  a_opc_ignore: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE1
    byte_valid_in && opc_start_in && s_q.st == COFD_IDLE && byte_in != COFD_OPC_ADD_RR
    |=> s_q.st == COFD_IDLE && !op_valid_out)
    else $error("foreign opcode acted on");

  a_state_onehot: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    $onehot(s_q.st))
    else $error("sequence state not one-hot");

  a_escape_map: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE2 RULE14
    byte_valid_in && !opc_start_in && s_q.st == COFD_IDLE && kind_in == COFD_K_REG
      && cofd_is_esc(byte_in)
    |=> reg_loc_out == $past(working_bank_base_in) + {4'h0, $past(byte_in[3:0])})
    else $error("escaped register not mapped to bank");

  a_plain_reg: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE3
    byte_valid_in && !opc_start_in && s_q.st == COFD_IDLE && kind_in == COFD_K_REG
      && !cofd_is_esc(byte_in)
    |=> reg_loc_out == $past(byte_in))
    else $error("plain register changed");

  a_bit_field: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE4 RULE13
    byte_valid_in && !opc_start_in && s_q.st == COFD_IDLE && kind_in == COFD_K_BITP
    |=> bit_sel_out == $past(byte_in[3:1]) && polarity_out == $past(byte_in[0]))
    else $error("bit or polarity wrong");

  a_rel_target: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE5
    byte_valid_in && !opc_start_in && s_q.st == COFD_IDLE && kind_in == COFD_K_REL
    |=> branch_target_out == $past(next_pc_in) + {{8{$past(byte_in[7])}}, $past(byte_in)})
    else $error("relative target wrong");

  a_idx_target: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE10
    byte_valid_in && !opc_start_in && s_q.st == COFD_IDLE && kind_in == COFD_K_IDX
    |=> indexed_loc_out == $past(index_base_in) + {{8{$past(byte_in[7])}}, $past(byte_in)})
    else $error("indexed location wrong");

  a_pair_even: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE6
    op_valid_out && $past(kind_in) == COFD_K_PAIR |-> pair_loc_out == {$past(byte_in[7:1]), 1'b0})
    else $error("pair address odd");

  a_wpair_even: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE7 RULE14
    op_valid_out && $past(kind_in) == COFD_K_WPAIR
    |-> pair_loc_out == $past(working_bank_base_in) + {4'h0, $past(byte_in[3:1]), 1'b0})
    else $error("working pair not even in bank");

  a_wide_join: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE8
    op_valid_out && $past(kind_in) == COFD_K_WIDE_LO
    |-> wide_file_operand_out == {$past(s_q.wide_hi), $past(byte_in)})
    else $error("wide operand join wrong");

  a_da_join: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE9
    op_valid_out && $past(kind_in) == COFD_K_DA_LO
    |-> full_16bit_location_out == {$past(s_q.da_hi), $past(byte_in)})
    else $error("direct address join wrong");

  // High halves only stage a value; reporting them would hand out half an address
  a_hi_silent: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE8 RULE9
    byte_valid_in && !opc_start_in && s_q.st == COFD_IDLE
      && (kind_in == COFD_K_WIDE_HI || kind_in == COFD_K_DA_HI)
    |=> !op_valid_out)
    else $error("high half reported as operand");

  a_kind_refuse: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
    byte_valid_in && !opc_start_in && s_q.st == COFD_IDLE && kind_in > COFD_K_IDX
    |=> !op_valid_out)
    else $error("unknown kind reported");

  a_imm_pass: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE11
    op_valid_out && $past(kind_in) == COFD_K_IMM |-> literal_byte_operand_out == $past(byte_in))
    else $error("immediate byte changed");

  a_vec_pass: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in) // RULE12
    op_valid_out && $past(kind_in) == COFD_K_VEC |-> vector_out == $past(byte_in))
    else $error("vector byte changed");

endmodule : cofd_operand_decoder

// *** rtl/cofd_pkg.sv ***
package cofd_pkg;

  // Opcode for register-to-register add
  localparam logic [7:0] COFD_OPC_ADD_RR   = 8'h04;
  // Escaped working register marker in an 8-bit register field
  localparam logic [3:0] COFD_ESC_NIBBLE   = 4'he;
  // Operand kinds carried with each instruction byte
  localparam logic [3:0] COFD_K_REG        = 4'h0;
  localparam logic [3:0] COFD_K_PAIR       = 4'h1;
  localparam logic [3:0] COFD_K_WPAIR      = 4'h2;
  localparam logic [3:0] COFD_K_WIDE_HI    = 4'h3;
  localparam logic [3:0] COFD_K_WIDE_LO    = 4'h4;
  localparam logic [3:0] COFD_K_DA_HI      = 4'h5;
  localparam logic [3:0] COFD_K_DA_LO      = 4'h6;
  localparam logic [3:0] COFD_K_IMM        = 4'h7;
  localparam logic [3:0] COFD_K_VEC        = 4'h8;
  localparam logic [3:0] COFD_K_BITP       = 4'h9;
  localparam logic [3:0] COFD_K_REL        = 4'ha;
  localparam logic [3:0] COFD_K_IDX        = 4'hb;
  // Field positions in a bit/polarity byte: polarity at bit 0, bit index at 3:1
  localparam int         COFD_POL_POS      = 0;
  localparam int         COFD_BIT_LSB      = 1;
  // Reset values
  localparam logic [7:0] COFD_RST_BYTE     = 8'h00;
  localparam logic [11:0] COFD_RST_ADDR12  = 12'h000;
  localparam logic [15:0] COFD_RST_ADDR16  = 16'h0000;

endpackage : cofd_pkg

// *** rtl/cofd_reg_map.sv ***
`timescale 1ns/1ps
module cofd_reg_map
  import cofd_pkg::*;
(
  // Raw field and bank pointer
  input  wire logic [7:0]  field_in,
  input  wire logic [7:0]  working_bank_base_in,
  // Resolved location
  output logic      [7:0]  loc_out,
  output logic             escaped_out
);

  always_comb
  begin
    escaped_out = (field_in[7:4] == COFD_ESC_NIBBLE); // RULE2
    if (escaped_out)
    begin
      loc_out = working_bank_base_in + {4'h0, field_in[3:0]}; // RULE14
    end
    else
    begin
      loc_out = field_in; // RULE3
    end
  end

endmodule : cofd_reg_map

// *** verif/cofd_fetch_model.sv ***
`timescale 1ns/1ps
module cofd_fetch_model
  import cofd_pkg::*;
(
  // Clock
  input  wire logic       sys_clk_in,
  // Fetched byte stream
  output logic            byte_valid_out,
  output logic [7:0]      byte_out,
  output logic            opc_start_out,
  output logic [3:0]      kind_out
);
  initial
  begin
    byte_valid_out = 1'b0;
    byte_out       = 8'h00;
    opc_start_out  = 1'b0;
    kind_out       = COFD_K_REG;
  end
  // Entered just past an edge; returns just past the taking edge
  task automatic send(input logic [7:0] b, input logic [3:0] k, input logic o, input logic last);
    byte_valid_out = 1'b1;
    byte_out       = b;
    opc_start_out  = o;
    kind_out       = k;
    @(posedge sys_clk_in);
    #1;
    if (last)
    begin
      // Released byte and kind lines show the inverse, valid and opcode start go low, so stale data never looks valid
      byte_valid_out = 1'b0;
      byte_out       = ~b;
      kind_out       = ~k;
      opc_start_out  = 1'b0;
    end
  endtask : send
endmodule : cofd_fetch_model

// *** verif/cpu_operand_field_decoder_tb.sv ***
`timescale 1ns/1ps
module cpu_operand_field_decoder_tb
  import cofd_pkg::*;
;
  typedef struct packed {logic [3:0] k; logic [7:0] b; logic [15:0] aux; logic [7:0] wb; logic [15:0] exp;} cofd_row_s;
  localparam cofd_row_s ROWS [20] = '{
    '{COFD_K_REG, 8'h43, 16'h0000, 8'h20, 16'h0043},
    '{COFD_K_REG, 8'hff, 16'h0000, 8'h20, 16'h00ff},
    '{COFD_K_REG, 8'he8, 16'h0000, 8'h20, 16'h0028},
    '{COFD_K_REG, 8'hef, 16'h0000, 8'hf8, 16'h0007},
    '{COFD_K_PAIR, 8'h37, 16'h0000, 8'h20, 16'h0036},
    '{COFD_K_PAIR, 8'hfe, 16'h0000, 8'h20, 16'h00fe},
    '{COFD_K_WPAIR, 8'hed, 16'h0000, 8'h20, 16'h002c},
    '{COFD_K_WPAIR, 8'he1, 16'h0000, 8'h40, 16'h0040},
    '{COFD_K_IMM, 8'h5a, 16'h0000, 8'h00, 16'h005a},
    '{COFD_K_IMM, 8'hff, 16'h0000, 8'h00, 16'h00ff},
    '{COFD_K_VEC, 8'h00, 16'h0000, 8'h00, 16'h0000},
    '{COFD_K_VEC, 8'hff, 16'h0000, 8'h00, 16'h00ff},
    '{COFD_K_BITP, 8'h0f, 16'h0000, 8'h00, 16'h000f},
    '{COFD_K_BITP, 8'h06, 16'h0000, 8'h00, 16'h0006},
    '{COFD_K_BITP, 8'h01, 16'h0000, 8'h00, 16'h0001},
    '{COFD_K_REL, 8'h80, 16'h1000, 8'h00, 16'h0f80},
    '{COFD_K_REL, 8'h7f, 16'h1000, 8'h00, 16'h107f},
    '{COFD_K_IDX, 8'h80, 16'h2000, 8'h00, 16'h1f80},
    '{COFD_K_IDX, 8'h7f, 16'hffff, 8'h00, 16'h007e},
    '{COFD_K_IDX, 8'h00, 16'h1234, 8'h00, 16'h1234}};
  logic        clk;
  logic        rst_n;
  logic [15:0] next_pc;
  logic [15:0] idx_base;
  logic [7:0]  wbase;
  logic        bv;
  logic [7:0]  bt;
  logic        os;
  logic [3:0]  kd;
  logic        add_done;
  logic        op_valid;
  logic        pol;
  logic [2:0]  bit_sel;
  logic [7:0]  src;
  logic [7:0]  dst;
  logic [7:0]  reg_loc;
  logic [7:0]  pair_loc;
  logic [7:0]  lit;
  logic [7:0]  vec;
  logic [11:0] wide;
  logic [15:0] full;
  logic [15:0] tgt;
  logic [15:0] idx_loc;
  int          failures = 0;
  int          checked = 0;
  wire logic   any_set = |{add_done, op_valid, pol, bit_sel, src, dst, reg_loc, pair_loc, lit, vec, wide, full, tgt, idx_loc};
  ////////////////////////////////////////////////////////////////////////////////
  cofd_fetch_model u_fetch (.sys_clk_in(clk), .byte_valid_out(bv), .byte_out(bt), .opc_start_out(os), .kind_out(kd));
  cofd_operand_decoder DUT (.sys_clk_in(clk), .reset_n_in(rst_n), .byte_valid_in(bv), .byte_in(bt),
    .opc_start_in(os), .kind_in(kd), .next_pc_in(next_pc), .index_base_in(idx_base), .working_bank_base_in(wbase),
    .add_done_out(add_done), .src_loc_out(src), .dst_loc_out(dst), .op_valid_out(op_valid), .reg_loc_out(reg_loc),
    .pair_loc_out(pair_loc), .wide_file_operand_out(wide), .full_16bit_location_out(full),
    .literal_byte_operand_out(lit), .vector_out(vec), .bit_sel_out(bit_sel), .polarity_out(pol),
    .branch_target_out(tgt), .indexed_loc_out(idx_loc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    if (failures == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // One idle cycle so the driver never reassigns valid in one time step
  task automatic gap();
    @(posedge clk);
    #1;
  endtask : gap
  function automatic logic [15:0] pick(input logic [3:0] k);
    case (k)
      COFD_K_REG:                pick = {8'h00, reg_loc};
      COFD_K_PAIR, COFD_K_WPAIR: pick = {8'h00, pair_loc};
      COFD_K_IMM:                pick = {8'h00, lit};
      COFD_K_VEC:                pick = {8'h00, vec};
      COFD_K_BITP:               pick = {12'h000, bit_sel, pol};
      COFD_K_REL:                pick = tgt;
      default:                   pick = idx_loc;
    endcase
  endfunction : pick
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Guard against a hang
  initial
  begin
    #100000;
    failures++;
    final_report();
  end
  initial
  begin
    rst_n = 1'b0;
    next_pc = 16'h0000;
    idx_base = 16'h0000;
    wbase = 8'h20;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    check({15'h0000, any_set}, 16'h0000);
    foreach (ROWS[i])
    begin
      next_pc = ROWS[i].aux;
      idx_base = ROWS[i].aux;
      wbase = ROWS[i].wb;
      u_fetch.send(ROWS[i].b, ROWS[i].k, 1'b0, 1'b1);
      check({15'h0000, op_valid}, 16'h0001);
      check(pick(ROWS[i].k), ROWS[i].exp);
      gap();
      check({15'h0000, op_valid}, 16'h0000);
    end
    // Paired bytes back to back; the high half must not report
    u_fetch.send(8'hf5, COFD_K_WIDE_HI, 1'b0, 1'b0);
    check({15'h0000, op_valid}, 16'h0000);
    u_fetch.send(8'hc3, COFD_K_WIDE_LO, 1'b0, 1'b0);
    check({4'h0, wide}, 16'h05c3);
    u_fetch.send(8'hab, COFD_K_DA_HI, 1'b0, 1'b0);
    u_fetch.send(8'hcd, COFD_K_DA_LO, 1'b0, 1'b1);
    check(full, 16'habcd);
    gap();
    wbase = 8'h20;
    u_fetch.send(COFD_OPC_ADD_RR, COFD_K_REG, 1'b1, 1'b1);
    gap();
    u_fetch.send(8'he8, COFD_K_IMM, 1'b0, 1'b1);
    check({op_valid, lit}, 16'h00ff);
    gap();
    u_fetch.send(8'h43, COFD_K_REG, 1'b0, 1'b0);
    check({15'h0000, add_done}, 16'h0001);
    check({src, dst}, 16'h2843);
    u_fetch.send(COFD_OPC_ADD_RR, COFD_K_REG, 1'b1, 1'b0);
    check({15'h0000, add_done}, 16'h0000);
    u_fetch.send(8'h08, COFD_K_REG, 1'b0, 1'b0);
    u_fetch.send(8'h43, COFD_K_REG, 1'b0, 1'b1);
    check({15'h0000, add_done}, 16'h0001);
    check({src, dst}, 16'h0843);
    gap();
    u_fetch.send(8'h05, COFD_K_REG, 1'b1, 1'b1);
    check({add_done, op_valid}, 16'h0000);
    gap();
    u_fetch.send(8'h11, COFD_K_REG, 1'b0, 1'b1);
    check({op_valid, reg_loc}, 16'h0111);
    gap();
    u_fetch.send(8'h22, 4'hc, 1'b0, 1'b1);
    check({15'h0000, op_valid}, 16'h0000);
    gap();
    rst_n = 1'b0;
    #1;
    check({15'h0000, any_set}, 16'h0000);
    gap();
    rst_n = 1'b1;
    // First byte right after a mid-run release must still decode
    u_fetch.send(8'he3, COFD_K_REG, 1'b0, 1'b1);
    check({op_valid, reg_loc}, 16'h0123);
    gap();
    check({15'h0000, op_valid}, 16'h0000);
    final_report();
  end
endmodule : cpu_operand_field_decoder_tb
